// ===== rtl/sccm_pkg.sv
package sccm_pkg;

   // Widths of the mask, the clock outputs and the general pins, and the mask bit layout
   localparam int MASK_W = 16;
   localparam int NUM_CLK = 10;
   localparam int GPIO_W = 4;
   localparam int PAIR_SLOTS = 4;
   localparam int SINGLE_FIRST = 8;
   localparam int SELF_CLK_BIT = 13;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [7:0] OFF_CLK_MASK = 8'h00;
   localparam logic [7:0] OFF_BRIDGE_CTRL = 8'h04;
   localparam logic [7:0] OFF_CHIP_CTRL = 8'h08;
   localparam logic [7:0] OFF_COMMAND = 8'h0c;
   localparam logic [7:0] OFF_GPIO_DATA = 8'h10;
   localparam logic [7:0] OFF_GPIO_OE = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;

   // Field positions
   localparam int BIT_SEC_RESET = 0;
   localparam int BIT_LIVE_MODE = 0;
   localparam int GPIO_SET_LSB = 0;
   localparam int GPIO_CLR_LSB = 4;
   localparam int ST_LOADING = 4;
   localparam int ST_SEC_RST = 5;
   localparam int ST_MASKED = 6;
   localparam int ST_LOADED = 7;
   localparam int GPIO_SCLK = 0;
   localparam int GPIO_MODE = 2;
   localparam int GPIO_LIVE = 3;

   // Values after reset, and the pin output enables used while loading
   localparam logic [MASK_W-1:0] RST_CLK_MASK = 16'h0000;
   localparam logic [GPIO_W-1:0] RST_GPIO = 4'h0;
   localparam logic [GPIO_W-1:0] LOAD_GPIO_OE = 4'h5;

   // Timing
   localparam int CORE_HZ = 25_000_000;
   localparam int SHIFT_MAX_HZ = 33_000_000;
   localparam int SHIFT_NOM_CYCLES = 23;
   localparam int SHIFT_FAST_CYCLES = 46;
   // Half period of the shift clock in core cycles, rounded up
   localparam int TICK_MIN =
      (CORE_HZ + 2 * SHIFT_MAX_HZ - 1) / (2 * SHIFT_MAX_HZ);
   // At least two cycles so the synchronised mask input settles
   localparam int TICK_CYCLES = (TICK_MIN < 2) ? 2 : TICK_MIN;
   localparam logic [3:0] LAST_SAMPLE = 4'hf;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_LOAD = 2'b01,
      SEQ_SHIFT = 2'b10
   } sccm_seq_e;

   typedef struct packed {
      logic master;
      logic mem;
      logic io;
   } sccm_cmd_s;

endpackage : sccm_pkg

// ===== rtl/sccm_mask_loader.sv
// Function
// - Shift sixteen serial mask bits into the clock mask register and gate clocks.
// - Start loading after primary reset release; hold secondary reset until done.
// - General pin 0 is the shift clock, below 33 MHz; pins 1,3 unused.
// - General pin 2 low means parallel load, high means shift.
// - Drive pin 2 low for one shift cycle, then high to shift.
// - Mask arrives most significant bit first, least significant bit last.
// - Bit pairs 1:0 to 7:6 gate clocks 0 to 3; any zero enables.
// - Bits 8 to 12 gate clocks 4 to 8; zero enables, one disables.
// - Bit 13 gates clock 9 for our own input; bits 14,15 unused.
// - Mask input tied high disables all clocks; tied low enables all.
// - After shifting, release general pins, ignore mask input, allow reset release.
// - Mask register is read/write by software; writes regate clocks quickly.
// - Secondary reset releases only after load, clocks already reflecting mask.
// - Live mode with pin 3 high forces io, memory, master enables off.
// - Command register reads stay unchanged; enables return when pin 3 drops.
// - While masked, already queued posted and delayed requests still finish.
// - While masked, delayed completions are not returned to masters.
// - Configuration transactions are always accepted in live mode.
// - Ten secondary clock outputs derived from the primary clock.
// - Secondary clock runs at the primary rate or half of it.
// - Divide by two when primary fast indicator high, secondary one low.
// - Secondary reset bit asserts reset until cleared and mask reloaded.
// - General pins come up input-only after reset.
//
// Implementation choices: the address map and the Avalon-MM register port.
module sccm_mask_loader
   import sccm_pkg::*;
(
   // Clock and reset
   input wire logic CORE_CLK_IN,
   input wire logic NRST_IN,
   // Avalon-MM slave
   input wire logic [7:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   // General pins and serial mask input
   input wire logic [GPIO_W-1:0] GPIO_IN,
   output logic [GPIO_W-1:0] GPIO_OUT,
   output logic [GPIO_W-1:0] GPIO_OE_OUT,
   input wire logic MSK_IN,
   // Frequency indicators
   input wire logic PRIMARY_FAST_INDICATOR_IN,
   input wire logic SECONDARY_FAST_INDICATOR_IN,
   // Secondary clocks and reset
   output logic [NUM_CLK-1:0] SEC_CLK_EN_OUT,
   output logic SEC_CLK_DIV2_OUT,
   output logic SEC_RST_N_OUT,
   // Forwarding enables
   output sccm_cmd_s FWD_EN_OUT,
   output logic QUEUE_DRAIN_EN_OUT,
   output logic COMPLETION_RET_EN_OUT,
   output logic CFG_ACCEPT_OUT
);

   // Pin synchronisers
   logic [GPIO_W-1:0] gpio_s1_q;
   logic [GPIO_W-1:0] gpio_s2_q;
   logic msk_s1_q;
   logic msk_s2_q;
   logic [1:0] fast_s1_q;
   logic [1:0] fast_s2_q;

   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         gpio_s1_q <= RST_GPIO;
         gpio_s2_q <= RST_GPIO;
         msk_s1_q <= 1'b0;
         msk_s2_q <= 1'b0;
         fast_s1_q <= 2'b00;
         fast_s2_q <= 2'b00;
      end else begin
         gpio_s1_q <= GPIO_IN;
         gpio_s2_q <= gpio_s1_q;
         msk_s1_q <= MSK_IN;
         msk_s2_q <= msk_s1_q;
         fast_s1_q <= {PRIMARY_FAST_INDICATOR_IN, SECONDARY_FAST_INDICATOR_IN};
         fast_s2_q <= fast_s1_q;
      end
   end

   // Bus handshake
   logic req;
   logic wr_take;
   logic waitreq_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   assign req = AVS_READ_IN | AVS_WRITE_IN;
   assign wr_take = AVS_WRITE_IN & ~waitreq_q;

   // Registers
   logic [MASK_W-1:0] clk_mask_q;
   logic sec_reset_bit_q;
   logic live_mode_q;
   sccm_cmd_s cmd_q;
   logic [GPIO_W-1:0] gpio_data_q;
   logic [GPIO_W-1:0] gpio_oe_q;

   // Load sequencer
   sccm_seq_e seq_q;
   logic loaded_q;
   logic [$clog2(TICK_CYCLES+1)-1:0] div_q;
   logic tick;
   logic sclk_q;
   logic mode_q;
   logic [3:0] bit_cnt_q;
   logic [MASK_W-1:0] shreg_q;
   logic load_done;
   logic sec_rst_active;

   assign tick = (div_q == ($bits(div_q))'(TICK_CYCLES - 1));
   assign sec_rst_active = sec_reset_bit_q | ~loaded_q;
   assign load_done = (seq_q == SEQ_SHIFT) & tick & ~sclk_q &
      (bit_cnt_q == LAST_SAMPLE);

   // Shift clock enable divider, kept at or below the maximum shift rate
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN || seq_q == SEQ_IDLE) begin
         div_q <= '0;
      end else if (tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // Load and shift sequence; a primary reset restarts it from idle
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         seq_q <= SEQ_IDLE;
         sclk_q <= 1'b0;
         mode_q <= 1'b1;
         bit_cnt_q <= 4'h0;
         shreg_q <= RST_CLK_MASK;
      end else begin
         unique case (seq_q)
            SEQ_IDLE: begin
               if (sec_rst_active && !loaded_q) begin
                  seq_q <= SEQ_LOAD;
                  mode_q <= 1'b0;
                  bit_cnt_q <= 4'h0;
               end
            end
            SEQ_LOAD: begin
               if (tick) begin
                  if (!sclk_q) begin
                     sclk_q <= 1'b1;
                  end else begin
                     sclk_q <= 1'b0;
                     mode_q <= 1'b1;
                     seq_q <= SEQ_SHIFT;
                  end
               end
            end
            SEQ_SHIFT: begin
               if (tick) begin
                  if (!sclk_q) begin
                     shreg_q <= {shreg_q[MASK_W-2:0], msk_s2_q};
                     bit_cnt_q <= bit_cnt_q + 1'b1;
                     if (bit_cnt_q == LAST_SAMPLE) begin
                        seq_q <= SEQ_IDLE;
                     end else begin
                        sclk_q <= 1'b1;
                     end
                  end else begin
                     sclk_q <= 1'b0;
                  end
               end
            end
            default: seq_q <= SEQ_IDLE;
         endcase
      end
   end

   // Loaded flag; setting the secondary reset bit calls for a new load
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         loaded_q <= 1'b0;
      end else if (load_done) begin
         loaded_q <= 1'b1;
      end else if (wr_take && AVS_ADDRESS_IN == OFF_BRIDGE_CTRL &&
                   AVS_BYTEENABLE_IN[0] &&
                   AVS_WRITEDATA_IN[BIT_SEC_RESET]) begin
         loaded_q <= 1'b0;
      end
   end

   // Clock mask register: loaded serially, then software owned
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         clk_mask_q <= RST_CLK_MASK;
      end else if (load_done) begin
         clk_mask_q <= {shreg_q[MASK_W-2:0], msk_s2_q};
      end else if (wr_take && AVS_ADDRESS_IN == OFF_CLK_MASK &&
                   seq_q == SEQ_IDLE) begin
         if (AVS_BYTEENABLE_IN[0]) begin
            clk_mask_q[7:0] <= AVS_WRITEDATA_IN[7:0];
         end
         if (AVS_BYTEENABLE_IN[1]) begin
            clk_mask_q[15:8] <= AVS_WRITEDATA_IN[15:8];
         end
      end
   end

   // Control registers
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         sec_reset_bit_q <= 1'b0;
         live_mode_q <= 1'b0;
         cmd_q <= '0;
      end else if (wr_take && AVS_BYTEENABLE_IN[0]) begin
         unique case (AVS_ADDRESS_IN)
            OFF_BRIDGE_CTRL: begin
               sec_reset_bit_q <= AVS_WRITEDATA_IN[BIT_SEC_RESET];
            end
            OFF_CHIP_CTRL: begin
               live_mode_q <= AVS_WRITEDATA_IN[BIT_LIVE_MODE];
            end
            OFF_COMMAND: begin
               cmd_q <= AVS_WRITEDATA_IN[2:0];
            end
            default: ;
         endcase
      end
   end

   // General pin registers, write one to set or clear
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         gpio_data_q <= RST_GPIO;
         gpio_oe_q <= RST_GPIO;
      end else if (wr_take && AVS_BYTEENABLE_IN[0]) begin
         if (AVS_ADDRESS_IN == OFF_GPIO_DATA) begin
            gpio_data_q <= (gpio_data_q |
               AVS_WRITEDATA_IN[GPIO_SET_LSB +: GPIO_W]) &
               ~AVS_WRITEDATA_IN[GPIO_CLR_LSB +: GPIO_W];
         end
         if (AVS_ADDRESS_IN == OFF_GPIO_OE) begin
            gpio_oe_q <= (gpio_oe_q |
               AVS_WRITEDATA_IN[GPIO_SET_LSB +: GPIO_W]) &
               ~AVS_WRITEDATA_IN[GPIO_CLR_LSB +: GPIO_W];
         end
      end
   end

   // Pin drive: the sequencer owns pins 0 and 2 while loading
   logic [GPIO_W-1:0] gpio_d;
   logic [GPIO_W-1:0] gpio_oe_d;
   always_comb begin
      if (seq_q != SEQ_IDLE) begin
         gpio_d = RST_GPIO;
         gpio_d[GPIO_SCLK] = sclk_q;
         gpio_d[GPIO_MODE] = mode_q;
         gpio_oe_d = LOAD_GPIO_OE;
      end else begin
         gpio_d = gpio_data_q;
         gpio_oe_d = gpio_oe_q;
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         GPIO_OUT <= RST_GPIO;
         GPIO_OE_OUT <= RST_GPIO;
      end else begin
         GPIO_OUT <= gpio_d;
         GPIO_OE_OUT <= gpio_oe_d;
      end
   end

   // Clock enables decoded from the mask
   logic [NUM_CLK-1:0] clk_en_d;

   for (genvar gi = 0; gi < NUM_CLK; gi++) begin : g_clk_en
      if (gi < PAIR_SLOTS) begin : g_pair
         assign clk_en_d[gi] =
            ~(clk_mask_q[2*gi] & clk_mask_q[2*gi+1]);
      end else if (gi < NUM_CLK - 1) begin : g_single
         assign clk_en_d[gi] =
            ~clk_mask_q[SINGLE_FIRST + gi - PAIR_SLOTS];
      end else begin : g_self
         assign clk_en_d[gi] = ~clk_mask_q[SELF_CLK_BIT];
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         SEC_CLK_EN_OUT <= '1;
         SEC_CLK_DIV2_OUT <= 1'b0;
      end else begin
         SEC_CLK_EN_OUT <= clk_en_d;
         SEC_CLK_DIV2_OUT <= fast_s2_q[1] & ~fast_s2_q[0];
      end
   end

   // Secondary reset, released a cycle after the clock enables settle
   logic rst_hold_q;
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         rst_hold_q <= 1'b1;
         SEC_RST_N_OUT <= 1'b0;
      end else begin
         rst_hold_q <= sec_rst_active | (seq_q != SEQ_IDLE);
         SEC_RST_N_OUT <= ~(rst_hold_q | sec_rst_active);
      end
   end

   // Live insertion masking of the forwarding enables
   logic live_mask;
   assign live_mask = live_mode_q & gpio_s2_q[GPIO_LIVE];

   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         FWD_EN_OUT <= '0;
         QUEUE_DRAIN_EN_OUT <= 1'b0;
         COMPLETION_RET_EN_OUT <= 1'b1;
         CFG_ACCEPT_OUT <= 1'b1;
      end else begin
         FWD_EN_OUT <= live_mask ? '0 : cmd_q;
         QUEUE_DRAIN_EN_OUT <= cmd_q.master;
         COMPLETION_RET_EN_OUT <= ~live_mask;
         CFG_ACCEPT_OUT <= 1'b1;
      end
   end

   // Read mux
   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (AVS_ADDRESS_IN)
         OFF_CLK_MASK: rdata_d[MASK_W-1:0] = clk_mask_q;
         OFF_BRIDGE_CTRL: rdata_d[BIT_SEC_RESET] = sec_reset_bit_q;
         OFF_CHIP_CTRL: rdata_d[BIT_LIVE_MODE] = live_mode_q;
         OFF_COMMAND: rdata_d[2:0] = cmd_q;
         OFF_GPIO_DATA: rdata_d[GPIO_W-1:0] = gpio_data_q;
         OFF_GPIO_OE: rdata_d[GPIO_W-1:0] = gpio_oe_q;
         OFF_STATUS: begin
            rdata_d[GPIO_W-1:0] = gpio_s2_q;
            rdata_d[ST_LOADING] = (seq_q != SEQ_IDLE);
            rdata_d[ST_SEC_RST] = ~SEC_RST_N_OUT;
            rdata_d[ST_MASKED] = live_mask;
            rdata_d[ST_LOADED] = loaded_q;
         end
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // One wait cycle per access
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         waitreq_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else if (req && waitreq_q) begin
         waitreq_q <= 1'b0;
         rdata_q <= AVS_READ_IN ? rdata_d : 32'h0000_0000;
      end else begin
         waitreq_q <= 1'b1;
      end
   end

   assign AVS_WAITREQUEST_OUT = waitreq_q;
   assign AVS_READDATA_OUT = rdata_q;

endmodule : sccm_mask_loader

// ===== test/sccm_mask_loader_properties.sv
module sccm_mask_loader_properties
   import sccm_pkg::*;
(
   input wire logic CORE_CLK_IN,
   input wire logic NRST_IN,
   input wire logic [GPIO_W-1:0] GPIO_OUT,
   input wire logic [GPIO_W-1:0] GPIO_OE_OUT,
   input wire logic PRIMARY_FAST_INDICATOR_IN,
   input wire logic SECONDARY_FAST_INDICATOR_IN,
   input wire logic [NUM_CLK-1:0] SEC_CLK_EN_OUT,
   input wire logic SEC_CLK_DIV2_OUT,
   input wire logic SEC_RST_N_OUT,
   input wire sccm_cmd_s FWD_EN_OUT,
   input wire logic QUEUE_DRAIN_EN_OUT,
   input wire logic COMPLETION_RET_EN_OUT,
   input wire logic CFG_ACCEPT_OUT
);
   logic [4:0] rise_cnt_q;

   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!NRST_IN);

   // Shift clock pulses of the current load
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN || $rose(GPIO_OE_OUT[GPIO_SCLK])) begin
         rise_cnt_q <= 5'h00;
      end else if ($rose(GPIO_OUT[GPIO_SCLK])) begin
         rise_cnt_q <= rise_cnt_q + 5'h01;
      end
   end

   load_start_a: assert property ($rose(NRST_IN) |-> ##[1:3]
      (GPIO_OE_OUT == LOAD_GPIO_OE && !GPIO_OUT[GPIO_MODE]))
      else $error("load did not start");
   mode_pulse_a: assert property ($rose(GPIO_OUT[GPIO_SCLK]) &&
      GPIO_OE_OUT[GPIO_MODE] && !GPIO_OUT[GPIO_MODE] |->
      ##[1:3] ($fell(GPIO_OUT[GPIO_SCLK]) && GPIO_OUT[GPIO_MODE]))
      else $error("mode pin not raised after load pulse");
   sclk_rate_a: assert property ($rose(GPIO_OUT[GPIO_SCLK]) &&
      GPIO_OE_OUT[GPIO_MODE] |=> $stable(GPIO_OUT[GPIO_SCLK]))
      else $error("shift clock too fast");
   pulse_count_a: assert property ($fell(GPIO_OE_OUT[GPIO_SCLK]) |->
      rise_cnt_q == 5'h10)
      else $error("wrong number of shift pulses");
   rst_hold_a: assert property (GPIO_OE_OUT[GPIO_MODE] |->
      !SEC_RST_N_OUT)
      else $error("secondary reset released during load");
   rst_release_a: assert property ($rose(SEC_RST_N_OUT) |->
      $stable(SEC_CLK_EN_OUT) && !GPIO_OE_OUT[GPIO_MODE])
      else $error("reset released before clocks settled");
   div2_sel_a: assert property ((PRIMARY_FAST_INDICATOR_IN &&
      !SECONDARY_FAST_INDICATOR_IN) [*5] |=> SEC_CLK_DIV2_OUT)
      else $error("divide by two not selected");
   drain_keep_a: assert property (FWD_EN_OUT.master |->
      QUEUE_DRAIN_EN_OUT)
      else $error("master enabled without drain enable");
   masked_off_a: assert property (!COMPLETION_RET_EN_OUT |->
      FWD_EN_OUT == 3'b000)
      else $error("enables open while completions held");
   cfg_accept_a: assert property (CFG_ACCEPT_OUT)
      else $error("configuration access refused");
endmodule : sccm_mask_loader_properties

bind sccm_mask_loader sccm_mask_loader_properties sccm_mask_loader_properties_i (
   .CORE_CLK_IN(CORE_CLK_IN), .NRST_IN(NRST_IN), .GPIO_OUT(GPIO_OUT),
   .GPIO_OE_OUT(GPIO_OE_OUT),
   .PRIMARY_FAST_INDICATOR_IN(PRIMARY_FAST_INDICATOR_IN),
   .SECONDARY_FAST_INDICATOR_IN(SECONDARY_FAST_INDICATOR_IN),
   .SEC_CLK_EN_OUT(SEC_CLK_EN_OUT), .SEC_CLK_DIV2_OUT(SEC_CLK_DIV2_OUT),
   .SEC_RST_N_OUT(SEC_RST_N_OUT), .FWD_EN_OUT(FWD_EN_OUT),
   .QUEUE_DRAIN_EN_OUT(QUEUE_DRAIN_EN_OUT),
   .COMPLETION_RET_EN_OUT(COMPLETION_RET_EN_OUT),
   .CFG_ACCEPT_OUT(CFG_ACCEPT_OUT));

// ===== test/sccm_shift_board.sv
module sccm_shift_board (
   input wire logic shift_clk_in,
   input wire logic mode_in,
   input wire logic fitted_in,
   input wire logic tie_lvl_in,
   input wire logic [15:0] par_in,
   output logic msk_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] sr_q = 16'h0000;

   // Refill with inverted bits so an extra shift shows up
   always @(posedge shift_clk_in) begin
      if (!mode_in) begin
         sr_q <= par_in;
      end else begin
         sr_q <= {sr_q[14:0], ~sr_q[15]};
      end
   end

   assign msk_out = fitted_in ? sr_q[15] : tie_lvl_in;
endmodule : sccm_shift_board

// ===== test/sccm_mask_loader_tb.sv
module sccm_mask_loader_tb
   import sccm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, rd, wr, pf, sf, fit, tie, wreq, div2, srst;
   logic drain, cret, cfg, msk;
   logic [7:0] adr;
   logic [31:0] wd, rdat, q;
   logic [3:0] ext, gout, goe, pin;
   logic [9:0] en;
   logic [15:0] par;
   sccm_cmd_s fwd;
   int fail_count, checks;

   // Undriven pins follow the board pull-downs or the insertion switch
   assign pin = (goe & gout) | (~goe & ext);

   sccm_mask_loader sccm_mask_loader_i (
      .CORE_CLK_IN(clk), .NRST_IN(nrst), .AVS_ADDRESS_IN(adr),
      .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
      .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdat),
      .AVS_WAITREQUEST_OUT(wreq), .GPIO_IN(pin), .GPIO_OUT(gout),
      .GPIO_OE_OUT(goe), .MSK_IN(msk), .PRIMARY_FAST_INDICATOR_IN(pf),
      .SECONDARY_FAST_INDICATOR_IN(sf), .SEC_CLK_EN_OUT(en),
      .SEC_CLK_DIV2_OUT(div2), .SEC_RST_N_OUT(srst), .FWD_EN_OUT(fwd),
      .QUEUE_DRAIN_EN_OUT(drain), .COMPLETION_RET_EN_OUT(cret),
      .CFG_ACCEPT_OUT(cfg));

   sccm_shift_board sccm_shift_board_i (
      .shift_clk_in(pin[GPIO_SCLK]), .mode_in(pin[GPIO_MODE]),
      .fitted_in(fit), .tie_lvl_in(tie), .par_in(par), .msk_out(msk));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic conclude();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic hang();
      fail_count++;
      $display("ERROR %0t: wait ran out", $time);
      conclude();
   endtask : hang

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (wreq === 1'b0) break;
      end
      if (n == 20) hang();
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic wait_rst();
      int n;
      for (n = 0; n < 300; n++) begin
         @(posedge clk);
         if (srst === 1'b1) break;
      end
      if (n == 300) hang();
      @(posedge clk);
   endtask : wait_rst

   function automatic logic [9:0] exp_en(input logic [15:0] m);
      logic [9:0] e;
      for (int i = 0; i < 4; i++) e[i] = ~(m[2*i] & m[2*i+1]);
      for (int i = 4; i < 9; i++) e[i] = ~m[i+4];
      e[9] = ~m[13];
      return e;
   endfunction : exp_en

   task automatic expect_mask(input logic [15:0] e);
      chk(32'(en), 32'(exp_en(e)));
      chk(32'(goe), 32'h0);
      bus(1'b0, OFF_CLK_MASK, 32'h0);
      chk(q, 32'(e));
   endtask : expect_mask

   // Abort the first load part way, then load a fresh pattern
   task automatic t_powerup();
      repeat (20) @(posedge clk);
      chk(32'(srst), 32'h0);
      par <= 16'h75e4;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      wait_rst();
      expect_mask(16'h75e4);
   endtask : t_powerup

   task automatic t_reload(input logic f, input logic t,
                           input logic [15:0] m, input logic [15:0] e);
      fit <= f;
      tie <= t;
      par <= m;
      bus(1'b1, OFF_BRIDGE_CTRL, 32'h1);
      repeat (100) @(posedge clk);
      chk(32'(srst), 32'h0);
      bus(1'b1, OFF_BRIDGE_CTRL, 32'h0);
      wait_rst();
      expect_mask(e);
   endtask : t_reload

   task automatic t_sw_mask();
      bus(1'b1, OFF_CLK_MASK, 32'h2a55);
      repeat (4) @(posedge clk);
      chk(32'(en), 32'(exp_en(16'h2a55)));
      bus(1'b0, OFF_CLK_MASK, 32'h0);
      chk(q, 32'h2a55);
      bus(1'b0, 8'h1c, 32'h0);
      chk(q, 32'h0);
   endtask : t_sw_mask

   // Pins go back to register control once the load is over
   task automatic t_gpio();
      bus(1'b1, OFF_GPIO_OE, 32'h2);
      bus(1'b1, OFF_GPIO_DATA, 32'h2);
      repeat (4) @(posedge clk);
      chk(32'(goe), 32'h2);
      chk(32'(gout), 32'h2);
      // Status: pin 1 high, mask loaded, no load or reset active
      bus(1'b0, OFF_STATUS, 32'h0);
      chk(q, 32'h82);
      bus(1'b1, OFF_GPIO_OE, 32'h20);
      bus(1'b1, OFF_GPIO_DATA, 32'h20);
      repeat (2) @(posedge clk);
      chk(32'(goe), 32'h0);
      chk(32'(gout), 32'h0);
   endtask : t_gpio

   task automatic t_live();
      bus(1'b1, OFF_COMMAND, 32'h7);
      // Pin 3 output enable stays clear, so the pin is input only
      bus(1'b1, OFF_CHIP_CTRL, 32'h1);
      ext <= 4'h8;
      repeat (6) @(posedge clk);
      chk(32'(fwd), 32'h0);
      chk(32'(cret), 32'h0);
      chk(32'(drain), 32'h1);
      chk(32'(cfg), 32'h1);
      bus(1'b0, OFF_COMMAND, 32'h0);
      chk(q, 32'h7);
      ext <= 4'h0;
      repeat (6) @(posedge clk);
      chk(32'(fwd), 32'h7);
      ext <= 4'h8;
      bus(1'b1, OFF_CHIP_CTRL, 32'h0);
      repeat (6) @(posedge clk);
      chk(32'(fwd), 32'h7);
   endtask : t_live

   task automatic t_div2();
      for (int i = 0; i < 4; i++) begin
         pf <= i[1];
         sf <= i[0];
         repeat (8) @(posedge clk);
         chk(32'(div2), (i == 2) ? 32'h1 : 32'h0);
      end
   endtask : t_div2

   initial begin
      nrst = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = 8'h00;
      wd = 32'h0;
      pf = 1'b0;
      sf = 1'b0;
      ext = 4'h0;
      fit = 1'b1;
      tie = 1'b0;
      par = 16'hffff;
      fail_count = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_powerup();
      t_reload(1'b1, 1'b0, 16'h8a1b, 16'h8a1b);
      t_reload(1'b0, 1'b1, 16'h1234, 16'hffff);
      t_reload(1'b0, 1'b0, 16'hffff, 16'h0000);
      t_sw_mask();
      t_gpio();
      t_live();
      t_div2();
      conclude();
   end
endmodule : sccm_mask_loader_tb
